// ===== rtl/tx_front_end_map.vh
`ifndef TX_FRONT_END_MAP_VH
`define TX_FRONT_END_MAP_VH
// Register select codes, {reg_select_hi, reg_select_lo}
`define SEL_TX_SAMPLE      2'h0
`define SEL_ECHO_SAMPLE    2'h1
`define SEL_POINTER        2'h2
`define SEL_CONTROL        2'h3
// Indirect pointer value that reaches the control register
`define CTRL_POINTER_ADDR  3'h0
`define POINTER_RESET      3'h0
// Control register fields
`define CTRL_RESET         8'hff
`define ATTEN_MSB          7
`define ATTEN_LSB          4
`define AUX_ROUTE_HI_BIT   2
`define AUX_ROUTE_LO_BIT   1
`define ATTEN_INFINITE_MIN 4'hc
`define ATTEN_STEP_DB      2
// Data byte fields
`define PTR_MSB            7
`define PTR_LSB            5
`define LOW_NIBBLE_MSB     7
`define LOW_NIBBLE_LSB     4
// Aux routing codes, {hi, lo}
`define ROUTE_FILTER       2'h1
`define ROUTE_ATTEN        2'h2
`define SAMPLE_RESET       12'h000
`endif

// ===== rtl/sample_fifo.v
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire [AW:0]     count = wr_ptr_reg - rd_ptr_reg;
  wire            empty = (count == {(AW+1){1'b0}});
  wire            pop = !empty && (!out_valid || out_ready);
  assign in_ready = (count != DEPTH[AW:0]) && (DEPTH < (1 << AW) || count[AW] == 1'b0);

  always @(posedge clk) begin
    if (ce && in_valid && in_ready) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      out_data   <= {WIDTH{1'b0}};
      out_valid  <= 1'b0;
    end else if (ce) begin
      if (in_valid && in_ready) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        out_data   <= mem[rd_ptr_reg[AW-1:0]];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_valid  <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/converter_mux.v
`timescale 1ns/10ps
`default_nettype none
`include "tx_front_end_map.vh"
// Single converter shared by both channels, phase chosen by conversion_clock
module converter_mux #(
  parameter SW = 12
) (
  input  wire          clk,
  input  wire          arst_n,
  input  wire          ce,
  input  wire          conversion_clock,
  input  wire [SW-1:0] tx_sample,
  input  wire [SW-1:0] echo_sample,
  output reg  [SW-1:0] dac_code,
  output reg           dac_is_echo,
  output reg  [SW-1:0] tx_hold,
  output reg  [SW-1:0] echo_hold
);
  reg conv_d_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_d_reg  <= 1'b0;
      dac_code    <= `SAMPLE_RESET;
      dac_is_echo <= 1'b0;
      tx_hold     <= `SAMPLE_RESET;
      echo_hold   <= `SAMPLE_RESET;
    end else if (ce) begin
      conv_d_reg  <= conversion_clock;
      dac_is_echo <= conversion_clock;
      dac_code    <= conversion_clock ? echo_sample : tx_sample;
      // Both holds refresh at the falling conversion edge
      if (conv_d_reg && !conversion_clock) begin
        tx_hold   <= tx_sample;
        echo_hold <= echo_sample;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tx_front_end_write_port.v
// How it works
// - Register loads on rising edge of the active-low enable strobe.
// - Writes happen only while read/write line is low.
// - Read/write high means unselected; the data bus is never driven.
// - Selected only with low-active select low and high-active select high.
// - Register selects steer bytes to sample or pointer/control registers.
// - Control register reached only when the pointer holds its address.
// - Data bus is eight bits, input only.
// - One 12-bit converter serves transmit and echo samples alternately.
// - Transmit converts with conversion clock low, echo with it high.
// - Both holds update at the conversion clock rate.
// - Attenuator covers 0 to -22 dB in 2 dB steps.
// - Codes 00/01 samples in two bytes, 10 pointer, 11 control.
// - Byte-phase toggles on sample writes; cleared on other enable edges.
// - Control bits 7..4 attenuate, bits 2..1 route aux; reset all ones.
// - Three-bit pointer from data 7..5, increments after each control access.
`timescale 1ns/10ps
`default_nettype none
`include "tx_front_end_map.vh"
module tx_front_end_write_port #(
  parameter SW    = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          clk,
  input  wire          arst_n,
  input  wire          ce,
  input  wire [7:0]    data_in,
  input  wire          enable_n,
  input  wire          read_write,
  input  wire          select_low_active,
  input  wire          select_high_active,
  input  wire          reg_select_lo,
  input  wire          reg_select_hi,
  input  wire          conversion_clock,
  input  wire          test_mode,
  output reg           write_ready,
  output reg  [SW-1:0] tx_sample_reg,
  output reg  [SW-1:0] echo_sample_reg,
  output reg  [7:0]    gain_route_ctrl_reg,
  output reg  [2:0]    indirect_pointer_reg,
  output reg  [3:0]    atten_code,
  output reg  [4:0]    atten_db,
  output reg           atten_infinite,
  output reg           aux_to_filter,
  output reg           aux_to_atten,
  output reg           byte_phase,
  output reg  [SW-1:0] dac_code,
  output reg           dac_is_echo,
  output reg  [SW-1:0] tx_hold,
  output reg  [SW-1:0] echo_hold
);
  // Decodes the low-active/high-active select pair with the write line
  function selected;
    input cs_lo;
    input cs_hi;
    input rw;
    begin
      selected = !cs_lo && cs_hi && !rw;
    end
  endfunction

  reg        enable_d_reg;
  reg [3:0]  low_nibble_reg;
  reg        phase_reg;
  reg [2:0]  pointer_reg;
  reg [7:0]  ctrl_reg;

  wire [1:0] sel_code = {reg_select_hi, reg_select_lo};
  // Data and selects are sampled at the edge the strobe rises on
  wire       strobe_rise = !enable_d_reg && enable_n;
  wire       sel = selected(select_low_active, select_high_active, read_write);
  wire       sample_sel = sel && (sel_code == `SEL_TX_SAMPLE || sel_code == `SEL_ECHO_SAMPLE);

  // Completed samples go through the FIFO, tagged by channel
  wire              fifo_in_valid = ce && strobe_rise && sample_sel && phase_reg;
  wire              fifo_in_ready;
  wire [SW:0]       fifo_in_data = {reg_select_lo, data_in, low_nibble_reg};
  wire [SW:0]       fifo_out_data;
  wire              fifo_out_valid;
  // Drain is held while the conversion clock is falling, so a latched sample stays stable
  reg               conv_d_reg;
  wire              drain_ok = !(conv_d_reg && !conversion_clock);
  wire [SW-1:0]     mux_code;
  wire              mux_echo;
  wire [SW-1:0]     mux_tx_hold;
  wire [SW-1:0]     mux_echo_hold;

  sample_fifo #(
    .WIDTH (SW + 1),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) sample_fifo_i (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .in_data   (fifo_in_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ok)
  );

  converter_mux #(
    .SW (SW)
  ) converter_mux_i (
    .clk              (clk),
    .arst_n           (arst_n),
    .ce               (ce),
    .conversion_clock (conversion_clock),
    .tx_sample        (tx_sample_reg),
    .echo_sample      (echo_sample_reg),
    .dac_code         (mux_code),
    .dac_is_echo      (mux_echo),
    .tx_hold          (mux_tx_hold),
    .echo_hold        (mux_echo_hold)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_d_reg   <= 1'b1;
      conv_d_reg     <= 1'b0;
      low_nibble_reg <= 4'h0;
      phase_reg      <= 1'b0;
      pointer_reg    <= `POINTER_RESET;
      ctrl_reg       <= `CTRL_RESET;
    end else if (ce) begin
      enable_d_reg <= enable_n;
      conv_d_reg   <= conversion_clock;
      if (strobe_rise) begin
        if (sample_sel) begin
          phase_reg <= !phase_reg;
          if (!phase_reg) begin
            low_nibble_reg <= data_in[`LOW_NIBBLE_MSB:`LOW_NIBBLE_LSB];
          end
        end else begin
          phase_reg <= 1'b0;
        end
        if (sel && sel_code == `SEL_POINTER) begin
          pointer_reg <= data_in[`PTR_MSB:`PTR_LSB];
        end
        // Every access with code 11 advances the pointer, matched or not
        if (sel && sel_code == `SEL_CONTROL) begin
          pointer_reg <= pointer_reg + 3'h1;
          if (pointer_reg == `CTRL_POINTER_ADDR) begin
            ctrl_reg <= data_in;
          end
        end
      end
    end
  end

  // Registered outputs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_ready          <= 1'b0;
      tx_sample_reg        <= `SAMPLE_RESET;
      echo_sample_reg      <= `SAMPLE_RESET;
      gain_route_ctrl_reg  <= `CTRL_RESET;
      indirect_pointer_reg <= `POINTER_RESET;
      atten_code           <= 4'hf;
      atten_db             <= 5'h00;
      atten_infinite       <= 1'b1;
      aux_to_filter        <= 1'b0;
      aux_to_atten         <= 1'b0;
      byte_phase           <= 1'b0;
      dac_code             <= `SAMPLE_RESET;
      dac_is_echo          <= 1'b0;
      tx_hold              <= `SAMPLE_RESET;
      echo_hold            <= `SAMPLE_RESET;
    end else if (ce) begin
      write_ready          <= fifo_in_ready;
      gain_route_ctrl_reg  <= ctrl_reg;
      indirect_pointer_reg <= pointer_reg;
      byte_phase           <= phase_reg;
      atten_code           <= ctrl_reg[`ATTEN_MSB:`ATTEN_LSB];
      atten_infinite       <= ctrl_reg[`ATTEN_MSB:`ATTEN_LSB] >= `ATTEN_INFINITE_MIN;
      // 0..22 dB, step 2 dB per code
      atten_db <= (ctrl_reg[`ATTEN_MSB:`ATTEN_LSB] >= `ATTEN_INFINITE_MIN) ? 5'h00 :
                  {ctrl_reg[`ATTEN_MSB:`ATTEN_LSB], 1'b0};
      aux_to_filter <= {ctrl_reg[`AUX_ROUTE_HI_BIT], ctrl_reg[`AUX_ROUTE_LO_BIT]} == `ROUTE_FILTER;
      aux_to_atten  <= {ctrl_reg[`AUX_ROUTE_HI_BIT], ctrl_reg[`AUX_ROUTE_LO_BIT]} == `ROUTE_ATTEN;
      if (fifo_out_valid && drain_ok) begin
        if (fifo_out_data[SW]) begin
          echo_sample_reg <= fifo_out_data[SW-1:0];
        end else begin
          tx_sample_reg <= fifo_out_data[SW-1:0];
        end
      end
      dac_code    <= mux_code;
      dac_is_echo <= mux_echo;
      tx_hold     <= mux_tx_hold;
      echo_hold   <= mux_echo_hold;
    end
  end
endmodule
`default_nettype wire

// ===== dv/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// Signal processor side of the write-only port
module host_bus_model (
  input  wire logic       clk,
  output logic      [7:0] data_in,
  output logic            enable_n,
  output logic            read_write,
  output logic            select_low_active,
  output logic            select_high_active,
  output logic            reg_select_lo,
  output logic            reg_select_hi
);
  initial begin
    data_in = 8'h00;
    enable_n = 1'b1;
    {read_write, select_low_active, select_high_active} = 3'b110;
    {reg_select_hi, reg_select_lo} = 2'h0;
  end
  // sel is {read_write, select_low_active, select_high_active}
  task write(input logic [1:0] code, input logic [7:0] d, input logic [2:0] sel);
    @(posedge clk);
    {read_write, select_low_active, select_high_active} <= sel;
    {reg_select_hi, reg_select_lo} <= code;
    data_in <= d;
    enable_n <= 1'b0;
    @(posedge clk);
    enable_n <= 1'b1;
    @(posedge clk);
    // Released bus shows inverted data so a stale byte never looks valid
    data_in <= ~d;
    {read_write, select_low_active, select_high_active} <= 3'b110;
  endtask
endmodule
`default_nettype wire

// ===== dv/tx_front_end_write_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module tx_front_end_write_port_checker (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ce,
  input wire logic [7:0] data_in,
  input wire logic       enable_n,
  input wire logic       read_write,
  input wire logic       select_low_active,
  input wire logic       select_high_active,
  input wire logic       reg_select_lo,
  input wire logic       reg_select_hi,
  input wire logic       conversion_clock,
  input wire logic [7:0] gain_route_ctrl_reg,
  input wire logic [2:0] indirect_pointer_reg,
  input wire logic [3:0] atten_code,
  input wire logic [4:0] atten_db,
  input wire logic       atten_infinite,
  input wire logic       aux_to_filter,
  input wire logic       aux_to_atten,
  input wire logic       byte_phase,
  input wire logic       dac_is_echo
);
  wire       sel = ce & !read_write & !select_low_active & select_high_active;
  wire [1:0] code = {reg_select_hi, reg_select_lo};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_pointer_load: assert property (
    sel && $rose(enable_n) && code == 2'h2 |-> ##2 indirect_pointer_reg == $past(data_in[7:5], 2))
    else $error("pointer load wrong");
  a_ctrl_write: assert property (
    sel && $rose(enable_n) && code == 2'h3 && indirect_pointer_reg == 3'h0
    |-> ##2 gain_route_ctrl_reg == $past(data_in, 2)) else $error("control write wrong");
  a_pointer_step: assert property (
    sel && $rose(enable_n) && code == 2'h3 |-> ##2 indirect_pointer_reg == $past(indirect_pointer_reg, 2) + 3'h1)
    else $error("pointer step wrong");
  a_unselected_idle: assert property (
    ce && $rose(enable_n) && !sel |-> ##2 indirect_pointer_reg == $past(indirect_pointer_reg, 2)
    && gain_route_ctrl_reg == $past(gain_route_ctrl_reg, 2)) else $error("unselected strobe wrote");
  a_phase_first: assert property (
    sel && $rose(enable_n) && !reg_select_hi && !byte_phase |-> ##[1:2] byte_phase)
    else $error("byte phase stuck");
  a_field_map: assert property (
    $stable(gain_route_ctrl_reg) |-> atten_code == gain_route_ctrl_reg[7:4]
    && aux_to_filter == (gain_route_ctrl_reg[2:1] == 2'h1) && aux_to_atten == (gain_route_ctrl_reg[2:1] == 2'h2))
    else $error("control fields wrong");
  a_atten_steps: assert property (
    $stable(atten_code) |-> atten_infinite == (atten_code >= 4'hc)
    && atten_db == (atten_infinite ? 5'h00 : {atten_code, 1'b0})) else $error("attenuation wrong");
  a_dac_phase: assert property (
    (conversion_clock == $past(conversion_clock))[*4] |-> dac_is_echo == conversion_clock)
    else $error("converter phase wrong");
endmodule
bind tx_front_end_write_port tx_front_end_write_port_checker checker_i (.clk, .arst_n, .ce, .data_in,
  .enable_n, .read_write, .select_low_active, .select_high_active, .reg_select_lo, .reg_select_hi,
  .conversion_clock, .gain_route_ctrl_reg, .indirect_pointer_reg, .atten_code, .atten_db, .atten_infinite,
  .aux_to_filter, .aux_to_atten, .byte_phase, .dac_is_echo);
`default_nettype wire

// ===== dv/tx_front_end_write_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module tx_front_end_write_port_test;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        test_mode = 1'b0;
  logic        conversion_clock = 1'b0;
  int          cc_cnt = 0;
  int          err_count = 0;
  int          compares = 0;
  int          c;
  wire  [7:0]  data_in, gain_route_ctrl_reg;
  wire  [11:0] tx_sample_reg, echo_sample_reg, dac_code, tx_hold, echo_hold;
  wire  [4:0]  atten_db;
  wire  [3:0]  atten_code;
  wire  [2:0]  indirect_pointer_reg;
  wire         enable_n, read_write, select_low_active, select_high_active, reg_select_lo, reg_select_hi;
  wire         write_ready, atten_infinite, aux_to_filter, aux_to_atten, byte_phase, dac_is_echo;
  logic [2:0]  bad_sel [3] = '{3'b101, 3'b011, 3'b000};
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cc_cnt <= (cc_cnt == 19) ? 0 : cc_cnt + 1;
    if (cc_cnt == 19) conversion_clock <= ~conversion_clock;
  end
  host_bus_model host_bus_model_i (.clk, .data_in, .enable_n, .read_write, .select_low_active,
    .select_high_active, .reg_select_lo, .reg_select_hi);
  tx_front_end_write_port #(.SW(12), .DEPTH(8), .AW(3)) tx_front_end_write_port_i (.clk, .arst_n, .ce,
    .data_in, .enable_n, .read_write, .select_low_active, .select_high_active, .reg_select_lo, .reg_select_hi,
    .conversion_clock, .test_mode, .write_ready, .tx_sample_reg, .echo_sample_reg, .gain_route_ctrl_reg,
    .indirect_pointer_reg, .atten_code, .atten_db, .atten_infinite, .aux_to_filter, .aux_to_atten,
    .byte_phase, .dac_code, .dac_is_echo, .tx_hold, .echo_hold);
  task chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] code, input logic [7:0] d, input logic [2:0] sel = 3'b001);
    host_bus_model_i.write(code, d, sel);
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Sample path runs through the buffer, so its delay is only bounded
  task wt(input logic [11:0] exp, input logic echo);
    int i;
    for (i = 0; i < 400 && (echo ? echo_sample_reg : tx_sample_reg) !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    chk(echo ? echo_sample_reg : tx_sample_reg, exp);
  endtask
  task results;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    results;
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk({gain_route_ctrl_reg, indirect_pointer_reg, atten_infinite}, 12'hff1);
    $display("reset test done");
    wr(2'h2, 8'he0);
    chk({9'h0, indirect_pointer_reg}, 12'h007);
    for (c = 0; c < 3; c++) begin
      wr(2'h2, 8'h20, bad_sel[c]);
      chk({9'h0, indirect_pointer_reg}, 12'h007);
    end
    $display("select test done");
    for (c = 0; c < 16; c++) begin
      wr(2'h2, 8'h00);
      wr(2'h3, {c[3:0], 1'b0, c[1:0], 1'b0});
      chk({1'b0, atten_db, atten_infinite, aux_to_filter, aux_to_atten, indirect_pointer_reg}, {1'b0,
        (c < 12) ? 5'(2 * c) : 5'h00, c >= 12, c[1:0] == 2'h1, c[1:0] == 2'h2, 3'h1});
    end
    wr(2'h3, 8'h00);
    chk({gain_route_ctrl_reg, indirect_pointer_reg, 1'b0}, 12'hf64);
    $display("control test done");
    wr(2'h0, 8'h30);
    chk({11'h0, byte_phase}, 12'h001);
    wr(2'h0, 8'hab);
    wt(12'hab3, 1'b0);
    wr(2'h1, 8'h5c);
    wr(2'h1, 8'h12);
    wt(12'h125, 1'b1);
    wr(2'h0, 8'h70);
    wr(2'h2, 8'h00);
    wr(2'h0, 8'h10);
    wr(2'h0, 8'h22);
    wt(12'h221, 1'b0);
    $display("sample test done");
    @(negedge conversion_clock);
    repeat (6) @(posedge clk);
    #1;
    chk(dac_code, 12'h221);
    chk(tx_hold, 12'h221);
    chk(echo_hold, 12'h125);
    @(posedge conversion_clock);
    repeat (6) @(posedge clk);
    #1;
    chk(dac_code, 12'h125);
    $display("converter test done");
    // Strobe while frozen must leave no trace once the clock enable returns
    @(posedge clk);
    ce <= 1'b0;
    wr(2'h2, 8'h40);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({9'h0, indirect_pointer_reg}, 12'h000);
    chk({11'h0, byte_phase}, 12'h000);
    $display("freeze test done");
    for (c = 1; c < 11; c++) begin
      wr(2'h0, {c[3:0], 4'h0});
      while (write_ready !== 1'b1) @(posedge clk);
      wr(2'h0, 8'(c));
    end
    wt(12'h0aa, 1'b0);
    $display("burst test done");
    results;
  end
endmodule
`default_nettype wire
